// ### inc/dsr_pkg.sv
// Package for the diagnostic status register bank
package dsr_pkg;
	localparam logic [7:0] ADDR_SENSOR_STATUS = 8'h57;
	localparam logic [7:0] ADDR_INPUT0_ALARM = 8'h58;
	localparam logic [7:0] ADDR_INPUT1_ALARM = 8'h59;
	localparam logic [7:0] ADDR_TEMP_ALARM = 8'h5A;
	localparam logic [7:0] ADDR_RSVD_5B = 8'h5B;
	localparam logic [7:0] ADDR_PKT_ERR_CNT = 8'h5C;
	localparam logic [7:0] ADDR_RX_ERR_FLAGS = 8'h5D;
	localparam logic [7:0] ADDR_LANES_LOW = 8'h5E;
	localparam logic [7:0] ADDR_LANES_HIGH = 8'h5F;
	localparam logic [7:0] ADDR_CLK_LANE = 8'h60;
	localparam logic [7:0] ADDR_HDR_CAPTURE = 8'h61;
	localparam logic [2:0] HIGH_RESET = 3'h0;
	localparam logic [2:0] LOW_RESET = 3'h7;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam int HIGH_LSB = 4;
	localparam int LOW_LSB = 0;
	localparam int SHORT_LINE_BIT = 3;
	localparam int CHECKSUM_BIT = 2;
	localparam int DOUBLE_BIT = 1;
	localparam int SINGLE_BIT = 0;
	localparam int LANE_HI_SYNC1_BIT = 7;
	localparam int LANE_HI_SYNCM_BIT = 6;
	localparam int LANE_HI_CTRL_BIT = 5;
	localparam int LANE_LO_SYNC1_BIT = 3;
	localparam int LANE_LO_SYNCM_BIT = 2;
	localparam int LANE_LO_CTRL_BIT = 1;
	localparam int CLK_CTRL_BIT = 1;
	localparam int VC_LSB = 6;

	// One monitored quantity: reading and limit comparisons
	typedef struct packed {
		logic [2:0] reading;
		logic above;
		logic below;
	} dsr_sense_t;

	// Receiver error events, one-cycle pulses
	typedef struct packed {
		logic pkt_err;
		logic short_line;
		logic checksum;
		logic hdr_double;
		logic hdr_single;
		logic [3:0] sync_single;
		logic [3:0] sync_multi;
		logic [3:0] hs_ctrl;
		logic clk_hs_ctrl;
	} dsr_rx_err_t;

	// Packet header capture
	typedef struct packed {
		logic valid;
		logic [1:0] vc;
		logic [5:0] dt;
	} dsr_hdr_t;
endpackage

// ### rtl/dsr_bank.sv
// Diagnostic status register bank: alarm readings, receive errors, header capture
// Overview of operation
// - Input0 high reading in bits 6:4, clear-on-read
// - Input0 low reading bits 2:0, resets seven
// - Input1 high reading bits 6:4, clear-on-read
// - Input1 low reading bits 2:0, resets seven
// - Temperature high reading bits 6:4, clear-on-read
// - Temperature low reading bits 2:0, resets seven
// - Eight-bit errored packet counter, cleared on read
// - Short line flag bit 3, clear-on-read
// - Payload checksum flag bit 2, clear-on-read
// - Header double error flag bit 1
// - Header single error flag bit 0
// - Per-lane sync single-bit error flags
// - Per-lane sync multi-bit error flags
// - Per-lane high-speed request control error flags
// - Lanes 3 and 2 in second register
// - Clock lane control error at bit 1
// - Virtual channel in header bits 7:6
// - Data type in header bits 5:0
// - Clear-on-read summary flag per alarm direction
`timescale 1ns/1ps
`default_nettype none
module dsr_bank
	import dsr_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	input wire dsr_sense_t I_INPUT0,
	input wire dsr_sense_t I_INPUT1,
	input wire dsr_sense_t I_TEMP,
	input wire dsr_rx_err_t I_RX_ERR,
	input wire dsr_hdr_t I_HDR
);
	logic [2:0] hi_q [3];
	logic [2:0] lo_q [3];
	logic [5:0] summary_q;
	logic [7:0] cnt_q;
	logic [3:0] rx_flags_q;
	logic [3:0] sync1_q;
	logic [3:0] syncm_q;
	logic [3:0] ctrl_q;
	logic clk_ctrl_q;
	logic [1:0] vc_q;
	logic [5:0] dt_q;
	logic [7:0] rdata_q;
	dsr_sense_t sense [3];
	logic [7:0] rd_mux;

	assign sense[0] = I_INPUT0;
	assign sense[1] = I_INPUT1;
	assign sense[2] = I_TEMP;

	function automatic logic rd_hit(input logic [7:0] a, input logic [7:0] r, input logic s);
		rd_hit = s && (a == r);
	endfunction

	logic [2:0] alarm_clr;
	assign alarm_clr = {rd_hit(I_ADDR, ADDR_TEMP_ALARM, I_RD), rd_hit(I_ADDR, ADDR_INPUT1_ALARM, I_RD),
		rd_hit(I_ADDR, ADDR_INPUT0_ALARM, I_RD)};

	// Alarm readings: new extreme wins over read clear
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			for (int k = 0; k < 3; k++) begin
				hi_q[k] <= HIGH_RESET;
				lo_q[k] <= LOW_RESET;
			end
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (sense[k].above && (alarm_clr[k] || sense[k].reading > hi_q[k])) begin
					hi_q[k] <= sense[k].reading;
				end else if (alarm_clr[k]) begin
					hi_q[k] <= HIGH_RESET;
				end
				if (sense[k].below && (alarm_clr[k] || sense[k].reading < lo_q[k])) begin
					lo_q[k] <= sense[k].reading;
				end else if (alarm_clr[k]) begin
					lo_q[k] <= LOW_RESET;
				end
			end
		end
	end

	// Summary flags: bit 2k low, bit 2k+1 high
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			summary_q <= 6'h00;
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (sense[k].below) begin
					summary_q[2*k] <= 1'b1;
				end else if (rd_hit(I_ADDR, ADDR_SENSOR_STATUS, I_RD)) begin
					summary_q[2*k] <= 1'b0;
				end
				if (sense[k].above) begin
					summary_q[2*k+1] <= 1'b1;
				end else if (rd_hit(I_ADDR, ADDR_SENSOR_STATUS, I_RD)) begin
					summary_q[2*k+1] <= 1'b0;
				end
			end
		end
	end

	// Errored packet counter
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cnt_q <= CNT_RESET;
		end else if (rd_hit(I_ADDR, ADDR_PKT_ERR_CNT, I_RD)) begin
			cnt_q <= I_RX_ERR.pkt_err ? 8'h01 : CNT_RESET;
		end else if (I_RX_ERR.pkt_err && cnt_q != CNT_MAX) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// Receive error flags, set wins over clear
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rx_flags_q <= 4'h0;
		end else begin
			rx_flags_q <= (rd_hit(I_ADDR, ADDR_RX_ERR_FLAGS, I_RD) ? 4'h0 : rx_flags_q)
				| {I_RX_ERR.short_line, I_RX_ERR.checksum, I_RX_ERR.hdr_double, I_RX_ERR.hdr_single};
		end
	end

	// Lane error flags: sticky until reset
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sync1_q <= 4'h0;
			syncm_q <= 4'h0;
			ctrl_q <= 4'h0;
			clk_ctrl_q <= 1'b0;
		end else begin
			sync1_q <= sync1_q | I_RX_ERR.sync_single;
			syncm_q <= syncm_q | I_RX_ERR.sync_multi;
			ctrl_q <= ctrl_q | I_RX_ERR.hs_ctrl;
			clk_ctrl_q <= clk_ctrl_q | I_RX_ERR.clk_hs_ctrl;
		end
	end

	// Header capture
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			vc_q <= 2'h0;
			dt_q <= 6'h00;
		end else if (I_HDR.valid) begin
			vc_q <= I_HDR.vc;
			dt_q <= I_HDR.dt;
		end
	end

	function automatic logic [7:0] lane_pair(input int lo, input logic [3:0] s1, input logic [3:0] sm,
		input logic [3:0] c);
		lane_pair = 8'h00;
		lane_pair[LANE_HI_SYNC1_BIT] = s1[lo+1];
		lane_pair[LANE_HI_SYNCM_BIT] = sm[lo+1];
		lane_pair[LANE_HI_CTRL_BIT] = c[lo+1];
		lane_pair[LANE_LO_SYNC1_BIT] = s1[lo];
		lane_pair[LANE_LO_SYNCM_BIT] = sm[lo];
		lane_pair[LANE_LO_CTRL_BIT] = c[lo];
	endfunction

	// Read multiplexer, unmapped reads zero
	always_comb begin
		rd_mux = 8'h00;
		case (I_ADDR)
			ADDR_SENSOR_STATUS: rd_mux = {2'b00, summary_q};
			ADDR_INPUT0_ALARM: rd_mux = {1'b0, hi_q[0], 1'b0, lo_q[0]};
			ADDR_INPUT1_ALARM: rd_mux = {1'b0, hi_q[1], 1'b0, lo_q[1]};
			ADDR_TEMP_ALARM: rd_mux = {1'b0, hi_q[2], 1'b0, lo_q[2]};
			ADDR_PKT_ERR_CNT: rd_mux = cnt_q;
			ADDR_RX_ERR_FLAGS: rd_mux = {4'h0, rx_flags_q};
			ADDR_LANES_LOW: rd_mux = lane_pair(0, sync1_q, syncm_q, ctrl_q);
			ADDR_LANES_HIGH: rd_mux = lane_pair(2, sync1_q, syncm_q, ctrl_q);
			ADDR_CLK_LANE: rd_mux = {6'h00, clk_ctrl_q, 1'b0};
			ADDR_HDR_CAPTURE: rd_mux = {vc_q, dt_q};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= I_RD ? rd_mux : 8'h00;
		end
	end
	assign O_RDATA = rdata_q;

	logic unused_wr;
	assign unused_wr = I_WR ^ (^I_WDATA);

	counter_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_PKT_ERR_CNT && !I_RX_ERR.pkt_err) |=> cnt_q == 8'h00)
		else $error("counter not cleared by read");
	counter_sat_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(cnt_q == 8'hFF && !(I_RD && I_ADDR == ADDR_PKT_ERR_CNT)) |=> cnt_q == 8'hFF)
		else $error("counter wrapped");
	short_line_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.short_line |=> rx_flags_q[SHORT_LINE_BIT])
		else $error("short line flag lost");
	checksum_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.checksum |=> rx_flags_q[CHECKSUM_BIT])
		else $error("checksum flag lost");
	double_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.hdr_double |=> rx_flags_q[DOUBLE_BIT])
		else $error("double error flag lost");
	single_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_RX_ERR_FLAGS && !I_RX_ERR.hdr_single) |=> !rx_flags_q[SINGLE_BIT])
		else $error("single error flag not cleared");
	lane_sync_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.sync_single[0] |=> ##1 (!$past(I_RD) || $past(I_ADDR) != ADDR_LANES_LOW || O_RDATA[3]))
		else $error("lane0 sync flag missing");
	clk_lane_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.clk_hs_ctrl |=> clk_ctrl_q)
		else $error("clock lane flag lost");
	low_reset_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_INPUT0_ALARM && !I_INPUT0.below) |=> lo_q[0] == 3'h7)
		else $error("low reading not cleared to seven");
	header_cap_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_HDR.valid |=> dt_q == $past(I_HDR.dt) && vc_q == $past(I_HDR.vc))
		else $error("header not captured");

	// Input0 alarm readings
	in0_high_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(!I_INPUT0.above && !(I_RD && I_ADDR == ADDR_INPUT0_ALARM)) |=> $stable(hi_q[0]))
		else $error("input0 high reading changed");
	in0_high_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_INPUT0_ALARM && !I_INPUT0.above) |=> hi_q[0] == HIGH_RESET)
		else $error("input0 high reading not cleared");
	in0_high_take_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_INPUT0.above && I_INPUT0.reading > hi_q[0]) |=> hi_q[0] == $past(I_INPUT0.reading))
		else $error("input0 high reading not taken");
	in0_low_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(!I_INPUT0.below && !(I_RD && I_ADDR == ADDR_INPUT0_ALARM)) |=> $stable(lo_q[0]))
		else $error("input0 low reading changed");
	in0_low_take_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_INPUT0.below && I_INPUT0.reading < lo_q[0]) |=> lo_q[0] == $past(I_INPUT0.reading))
		else $error("input0 low reading not taken");

	// Input1 alarm readings
	in1_high_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(!I_INPUT1.above && !(I_RD && I_ADDR == ADDR_INPUT1_ALARM)) |=> $stable(hi_q[1]))
		else $error("input1 high reading changed");
	in1_high_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_INPUT1_ALARM && !I_INPUT1.above) |=> hi_q[1] == HIGH_RESET)
		else $error("input1 high reading not cleared");
	in1_high_take_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_INPUT1.above && I_INPUT1.reading > hi_q[1]) |=> hi_q[1] == $past(I_INPUT1.reading))
		else $error("input1 high reading not taken");
	in1_low_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(!I_INPUT1.below && !(I_RD && I_ADDR == ADDR_INPUT1_ALARM)) |=> $stable(lo_q[1]))
		else $error("input1 low reading changed");
	in1_low_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_INPUT1_ALARM && !I_INPUT1.below) |=> lo_q[1] == LOW_RESET)
		else $error("input1 low reading not cleared");
	in1_low_take_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_INPUT1.below && I_INPUT1.reading < lo_q[1]) |=> lo_q[1] == $past(I_INPUT1.reading))
		else $error("input1 low reading not taken");

	// Temperature alarm readings
	temp_high_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(!I_TEMP.above && !(I_RD && I_ADDR == ADDR_TEMP_ALARM)) |=> $stable(hi_q[2]))
		else $error("temperature high reading changed");
	temp_high_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_TEMP_ALARM && !I_TEMP.above) |=> hi_q[2] == HIGH_RESET)
		else $error("temperature high reading not cleared");
	temp_high_take_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_TEMP.above && I_TEMP.reading > hi_q[2]) |=> hi_q[2] == $past(I_TEMP.reading))
		else $error("temperature high reading not taken");
	temp_low_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(!I_TEMP.below && !(I_RD && I_ADDR == ADDR_TEMP_ALARM)) |=> $stable(lo_q[2]))
		else $error("temperature low reading changed");
	temp_low_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_TEMP_ALARM && !I_TEMP.below) |=> lo_q[2] == LOW_RESET)
		else $error("temperature low reading not cleared");
	temp_low_take_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_TEMP.below && I_TEMP.reading < lo_q[2]) |=> lo_q[2] == $past(I_TEMP.reading))
		else $error("temperature low reading not taken");

	// Summary flags
	in0_above_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_INPUT0.above |=> summary_q[1])
		else $error("input0 above flag missing");
	in0_below_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_INPUT0.below |=> summary_q[0])
		else $error("input0 below flag missing");
	in1_above_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_INPUT1.above |=> summary_q[3])
		else $error("input1 above flag missing");
	in1_below_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_INPUT1.below |=> summary_q[2])
		else $error("input1 below flag missing");
	temp_above_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_TEMP.above |=> summary_q[5])
		else $error("temperature above flag missing");
	temp_below_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_TEMP.below |=> summary_q[4])
		else $error("temperature below flag missing");
	summary_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_SENSOR_STATUS && !I_INPUT0.above && !I_INPUT0.below && !I_INPUT1.above
		&& !I_INPUT1.below && !I_TEMP.above && !I_TEMP.below) |=> summary_q == 6'h00)
		else $error("summary flags not cleared");

	// Counter and receive flags
	counter_step_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RX_ERR.pkt_err && !(I_RD && I_ADDR == ADDR_PKT_ERR_CNT) && cnt_q != CNT_MAX)
		|=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("counter did not step");
	counter_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(!I_RX_ERR.pkt_err && !(I_RD && I_ADDR == ADDR_PKT_ERR_CNT)) |=> $stable(cnt_q))
		else $error("counter changed without error");
	short_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_RX_ERR_FLAGS && !I_RX_ERR.short_line) |=> !rx_flags_q[SHORT_LINE_BIT])
		else $error("short line flag not cleared");
	checksum_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_RX_ERR_FLAGS && !I_RX_ERR.checksum) |=> !rx_flags_q[CHECKSUM_BIT])
		else $error("checksum flag not cleared");
	double_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_RX_ERR_FLAGS && !I_RX_ERR.hdr_double) |=> !rx_flags_q[DOUBLE_BIT])
		else $error("double error flag not cleared");
	rx_flags_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!(I_RD && I_ADDR == ADDR_RX_ERR_FLAGS) |=> (rx_flags_q & $past(rx_flags_q)) == $past(rx_flags_q))
		else $error("receive flag lost without read");

	// Lane flags and header
	sync_single_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.sync_single != 4'h0 |=> (sync1_q & $past(I_RX_ERR.sync_single)) == $past(I_RX_ERR.sync_single))
		else $error("lane sync single flag lost");
	sync_multi_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.sync_multi != 4'h0 |=> (syncm_q & $past(I_RX_ERR.sync_multi)) == $past(I_RX_ERR.sync_multi))
		else $error("lane sync multi flag lost");
	lane_ctrl_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		I_RX_ERR.hs_ctrl != 4'h0 |=> (ctrl_q & $past(I_RX_ERR.hs_ctrl)) == $past(I_RX_ERR.hs_ctrl))
		else $error("lane control flag lost");
	header_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!I_HDR.valid |=> $stable(vc_q) && $stable(dt_q))
		else $error("header changed without valid");

	// Read path
	read_idle_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		!I_RD |=> O_RDATA == 8'h00)
		else $error("read data not zero when idle");
	read_reserved_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_RSVD_5B) |=> O_RDATA == 8'h00)
		else $error("reserved register not zero");
	read_in0_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_INPUT0_ALARM) |=> O_RDATA == {1'b0, $past(hi_q[0]), 1'b0, $past(lo_q[0])})
		else $error("input0 read data wrong");
	read_in1_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_INPUT1_ALARM) |=> O_RDATA == {1'b0, $past(hi_q[1]), 1'b0, $past(lo_q[1])})
		else $error("input1 read data wrong");
	read_temp_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_TEMP_ALARM) |=> O_RDATA == {1'b0, $past(hi_q[2]), 1'b0, $past(lo_q[2])})
		else $error("temperature read data wrong");
	read_counter_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_PKT_ERR_CNT) |=> O_RDATA == $past(cnt_q))
		else $error("counter read data wrong");
	read_rx_flags_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_RX_ERR_FLAGS) |=> O_RDATA == {4'h0, $past(rx_flags_q)})
		else $error("receive flags read data wrong");
	read_lanes_low_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_LANES_LOW) |=> O_RDATA[7] == $past(sync1_q[1]) && O_RDATA[3] == $past(sync1_q[0]))
		else $error("low lane pair read data wrong");
	read_lanes_high_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_LANES_HIGH) |=> !O_RDATA[4] && !O_RDATA[0] && O_RDATA[6] == $past(syncm_q[3]))
		else $error("high lane pair read data wrong");
	read_clk_lane_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_CLK_LANE) |=> O_RDATA == {6'h00, $past(clk_ctrl_q), 1'b0})
		else $error("clock lane read data wrong");
	read_header_a: assert property (@(posedge I_REF_CLK) disable iff (!I_NRST)
		(I_RD && I_ADDR == ADDR_HDR_CAPTURE) |=> O_RDATA == {$past(vc_q), $past(dt_q)})
		else $error("header read data wrong");
endmodule
`default_nettype wire

// ### tb/dsr_bank_tb.sv
// Self-checking bench for the diagnostic status register bank
`timescale 1ns/1ps
`default_nettype none
module dsr_bank_tb
	import dsr_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] rdata;
	dsr_sense_t sense [3];
	logic go = 1'b0;
	dsr_rx_err_t cmd = '0;
	dsr_hdr_t hcmd = '0;
	dsr_rx_err_t rx_err;
	dsr_hdr_t hdr;
	dsr_rx_err_t e;
	dsr_hdr_t h;
	int bad_count = 0;
	int checks = 0;
	integer seed = 32'h383AC887;
	logic [2:0] a, b, c;
	logic [7:0] v = 8'h00;
	logic [3:0] ss, sm, hc;
	logic ck;
	int n;

	always #12.5 clk = ~clk;

	dsr_bank dut_u (.I_REF_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(8'hA5), .I_WR(wr), .I_RD(rd_s),
		.O_RDATA(rdata), .I_INPUT0(sense[0]), .I_INPUT1(sense[1]), .I_TEMP(sense[2]), .I_RX_ERR(rx_err), .I_HDR(hdr));
	dsr_csi_tx tx_u (.i_clk(clk), .i_nrst(nrst), .i_go(go), .i_err(cmd), .i_hdr(hcmd), .o_err(rx_err), .o_hdr(hdr));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge clk) begin
			rd_s <= 1'b1;
			addr <= ad;
		end
		@(posedge clk) rd_s <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task drive(input int k, input logic [2:0] r, input logic up, input logic dn);
		@(posedge clk) sense[k] <= '{r, up, dn};
	endtask
	task automatic fire(input dsr_rx_err_t ev, input dsr_hdr_t hv, input int cnt);
		@(posedge clk) begin
			go <= 1'b1;
			cmd <= ev;
			hcmd <= hv;
		end
		repeat (cnt - 1) @(posedge clk);
		@(posedge clk) go <= 1'b0;
	endtask
	function automatic logic [7:0] pair_exp(input int lo);
		return {ss[lo + 1], sm[lo + 1], hc[lo + 1], 1'b0, ss[lo], sm[lo], hc[lo], 1'b0};
	endfunction
	task automatic close_out();
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#2000000;
		bad_count++;
		close_out();
	end

	initial begin
		for (int k = 0; k < 3; k++) sense[k] = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		for (int k = 8'h57; k <= 8'h62; k++) rd(8'(k), (k >= 8'h58 && k <= 8'h5A) ? 8'h07 : 8'h00);
		for (int k = 0; k < 3; k++) begin
			a = 3'($unsigned($random(seed)) % 7 + 1);
			b = 3'($unsigned($random(seed)) % 7 + 1);
			c = 3'($unsigned($random(seed)) % 7);
			drive(k, a, 1'b1, 1'b0);
			drive(k, b, 1'b1, 1'b0);
			drive(k, c, 1'b0, 1'b1);
			drive(k, 3'h0, 1'b0, 1'b0);
			rd(ADDR_INPUT0_ALARM + 8'(k), {1'b0, (a > b) ? a : b, 1'b0, c});
			rd(ADDR_INPUT0_ALARM + 8'(k), 8'h07);
			rd(ADDR_SENSOR_STATUS, 8'(3 << (2 * k)));
		end
		@(posedge clk) begin
			wr <= 1'b1;
			addr <= ADDR_INPUT0_ALARM;
		end
		@(posedge clk) wr <= 1'b0;
		rd(ADDR_INPUT0_ALARM, 8'h07);
		e = '0;
		e.pkt_err = 1'b1;
		n = 1 + $unsigned($random(seed)) % 20;
		fire(e, '0, n);
		rd(ADDR_PKT_ERR_CNT, 8'(n));
		rd(ADDR_PKT_ERR_CNT, 8'h00);
		fire(e, '0, 300);
		rd(ADDR_PKT_ERR_CNT, CNT_MAX);
		// Error lands in the same cycle as the clearing read
		@(posedge clk) begin
			go <= 1'b1;
			cmd <= e;
		end
		@(posedge clk) begin
			go <= 1'b0;
			rd_s <= 1'b1;
			addr <= ADDR_PKT_ERR_CNT;
		end
		@(posedge clk) rd_s <= 1'b0;
		#1 chk(rdata, 8'h00);
		rd(ADDR_PKT_ERR_CNT, 8'h01);
		for (int f = 0; f < 4; f++) begin
			e = '0;
			e[16:13] = 4'(1 << f);
			fire(e, '0, 1);
			rd(ADDR_RX_ERR_FLAGS, 8'(1 << f));
			rd(ADDR_RX_ERR_FLAGS, 8'h00);
		end
		{ss, sm, hc, ck} = '0;
		for (int r = 0; r < 2; r++) begin
			e = '0;
			e.sync_single = r ? 4'hF : 4'($random(seed));
			e.sync_multi = r ? 4'hF : 4'($random(seed));
			e.hs_ctrl = r ? 4'hF : 4'($random(seed));
			e.clk_hs_ctrl = 1'(r);
			ss = ss | e.sync_single;
			sm = sm | e.sync_multi;
			hc = hc | e.hs_ctrl;
			ck = ck | e.clk_hs_ctrl;
			fire(e, '0, 1);
			repeat (2) begin
				rd(ADDR_LANES_LOW, pair_exp(0));
				rd(ADDR_LANES_HIGH, pair_exp(2));
				rd(ADDR_CLK_LANE, {6'h00, ck, 1'b0});
			end
		end
		for (int r = 0; r < 4; r++) begin
			h = 9'($random(seed));
			h.vc = 2'(r);
			h.valid = h.valid | (r == 3);
			if (h.valid) v = {h.vc, h.dt};
			fire('0, h, 1);
			rd(ADDR_HDR_CAPTURE, v);
		end
		close_out();
	end
endmodule
`default_nettype wire

// ### tb/dsr_csi_tx.sv
// Model of the image sensor transmitter that raises receive events
`timescale 1ns/1ps
`default_nettype none
module dsr_csi_tx
	import dsr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_go,
	input wire dsr_rx_err_t i_err,
	input wire dsr_hdr_t i_hdr,
	output var dsr_rx_err_t o_err,
	output var dsr_hdr_t o_hdr
);
	// One event per cycle of go; nothing lingers afterwards
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_err <= '0;
			o_hdr <= '0;
		end else begin
			o_err <= i_go ? i_err : '0;
			o_hdr <= i_go ? i_hdr : '0;
		end
	end
endmodule
`default_nettype wire
